// >>> hw/co2ms_pkg.sv
// co2ms_pkg: constants and types of the carbon dioxide monitor sequencer.
// assumes a 20 MHz system clock and a 10-bit converted emf reading.
package co2ms_pkg;
    // ------------------------------------------------------------
    // clock and time
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int SEC_PER_MIN = 60;
    localparam int MIN_CYC = SEC_PER_MIN * CLK_HZ;
    localparam int MEAS_PERIOD_MS = 1000;
    localparam int MEAS_CYC = (CLK_HZ / 1000) * MEAS_PERIOD_MS;
    localparam logic [13:0] WARMUP_SHORT_MIN = 14'd30;
    localparam logic [13:0] WARMUP_LONG_MIN = 14'd120;
    localparam logic [13:0] MIN_PER_DAY = 14'd1440;
    localparam logic [13:0] STEP_INTERVAL_SHORT_MIN = MIN_PER_DAY;
    localparam logic [13:0] STEP_INTERVAL_LONG_MIN = 14'd7 * MIN_PER_DAY;
    // ------------------------------------------------------------
    // concentration scale
    // ------------------------------------------------------------
    localparam logic [11:0] PPM_AMBIENT = 12'h190;
    localparam logic [11:0] PPM_MAX = 12'hbb8;
    localparam logic [11:0] PPM_PER_LSB = 12'h005;
    localparam logic [11:0] STEP_LEVEL_HIGH_PPM = 12'h005;
    localparam logic [11:0] STEP_LEVEL_LOW_PPM = 12'h014;
    localparam logic [11:0] CTRL_ON_PPM = 12'h3e8;
    localparam logic [11:0] CTRL_OFF_PPM = 12'h320;
    localparam logic [11:0] PWM_PERIOD = 12'hbb8;
    localparam logic [11:0] TEMP_REF = 12'h080;
    localparam int TEMP_SHIFT = 3;
    localparam logic [9:0] EMF_MAX = 10'h3ff;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic warmup_select_strap;
        logic benchmark_step_level;
        logic benchmark_step_interval;
        logic line_test;
    } co2ms_strap_t;
    typedef enum logic [1:0] {
        ST_LATCH,
        ST_WARMUP,
        ST_RUN
    } co2ms_state_t;
    localparam co2ms_strap_t STRAP_RESET = 4'h0;
endpackage

// >>> hw/co2ms_top.sv
// co2ms_top: strap capture, warm-up timer, benchmark tracking,
// concentration pwm and on/off control of the co2 monitor.
// assumes emf and temperature words come from converter logic on clk.
// Functional notes
// R1: warm-up timer starts at power-on first
// R2: after warm-up, run and drive outputs
// R3: strap high 30 min, low 120 min
// R4: no valid measurement output during warm-up
// R5: straps captured once at power-on
// R6: periodic concentration from benchmark minus emf
// R7: lower concentration overwrites benchmark with emf
// R8: benchmark emf stands for 400 ppm
// R9: concentration reported as pwm output
// R10: separate on/off control output drives equipment
// R11: results span 400 to 3000 ppm
// R12: temperature compensation before concentration math
// R13: line test mode exercises controller outputs
// R14: unrenewed benchmark raised by step level
// R15: control output held high during warm-up
// R16: warm-up counts ticks, restarts on reset only
module co2ms_top
    import co2ms_pkg::*;
#(
    parameter int unsigned CYC_PER_MIN = MIN_CYC,
    parameter int unsigned CYC_PER_MEAS = MEAS_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire co2ms_strap_t strap_pins,
    input wire logic [9:0] emf_data,
    input wire logic [11:0] temp_data,
    output logic pwm_out,
    output logic ctrl_out,
    output logic [11:0] ppm_value,
    output logic running
);
    // ------------------------------------------------------------
    // strap capture and sequencing
    // ------------------------------------------------------------
    co2ms_strap_t sync1_r, sync2_r, straps_r, straps_nxt;
    co2ms_state_t state_r, state_nxt;
    logic [1:0] latch_cnt_r, latch_cnt_nxt;
    logic [30:0] min_div_r, min_div_nxt;
    logic [13:0] min_cnt_r, min_cnt_nxt;
    logic [13:0] warm_len;
    logic min_tick;

    assign min_tick = (min_div_r == 31'(CYC_PER_MIN - 1));
    // duration follows the latched copy, so a late strap change is harmless
    assign warm_len = straps_r.warmup_select_strap ? WARMUP_SHORT_MIN
                                                   : WARMUP_LONG_MIN; // see R3

    always_comb begin
        straps_nxt = straps_r;
        state_nxt = state_r;
        latch_cnt_nxt = latch_cnt_r;
        min_div_nxt = min_tick ? 31'h0 : min_div_r + 31'h1;
        min_cnt_nxt = min_cnt_r;
        case (state_r)
            ST_LATCH: begin
                // wait until the synchroniser holds post-reset pin levels
                latch_cnt_nxt = latch_cnt_r + 2'h1;
                if (latch_cnt_r == 2'h2) begin
                    straps_nxt = sync2_r; // see R5
                    min_div_nxt = 31'h0;
                    min_cnt_nxt = 14'h0;
                    state_nxt = ST_WARMUP; // see R1
                end
            end
            ST_WARMUP: begin
                if (straps_r.line_test) begin
                    state_nxt = ST_RUN; // see R13
                end else if (min_tick) begin
                    min_cnt_nxt = min_cnt_r + 14'h1; // see R16
                    if (min_cnt_r == warm_len - 14'h1) begin
                        state_nxt = ST_RUN; // see R2
                    end
                end
            end
            ST_RUN: begin
            end
            default: begin
                state_nxt = ST_LATCH;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        sync1_r <= strap_pins;
        sync2_r <= sync1_r;
        if (reset) begin
            straps_r <= STRAP_RESET;
            state_r <= ST_LATCH; // see R16
            latch_cnt_r <= 2'h0;
            min_div_r <= 31'h0;
            min_cnt_r <= 14'h0;
        end else begin
            straps_r <= straps_nxt;
            state_r <= state_nxt;
            latch_cnt_r <= latch_cnt_nxt;
            min_div_r <= min_div_nxt;
            min_cnt_r <= min_cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // compensation, benchmark and concentration
    // ------------------------------------------------------------
    logic [24:0] meas_cnt_r, meas_cnt_nxt;
    logic [9:0] bench_r, bench_nxt;
    logic bench_set_r, bench_set_nxt;
    logic [11:0] ppm_r, ppm_nxt;
    logic [13:0] idle_r, idle_nxt;
    logic signed [12:0] comp_s;
    logic [9:0] comp;
    logic [11:0] delta, ppm_raw, step_lsb;
    logic [13:0] step_len;
    logic meas_tick, renew, step_ev;
    logic [10:0] bench_up;

    // coarse linear correction; a finer curve would need a lookup table
    assign comp_s = $signed({3'h0, emf_data})
                  + ($signed({1'b0, temp_data} - {1'b0, TEMP_REF})
                     >>> TEMP_SHIFT); // see R12
    assign comp = comp_s < 0 ? 10'h0
                : comp_s > $signed({3'h0, EMF_MAX}) ? EMF_MAX
                : comp_s[9:0];
    assign meas_tick = (state_r == ST_RUN)
                     && (meas_cnt_r == 25'(CYC_PER_MEAS - 1)); // see R6
    assign renew = meas_tick && (!bench_set_r || comp > bench_r); // see R7
    assign delta = {2'h0, bench_r} - {2'h0, comp};
    assign ppm_raw = 12'(PPM_AMBIENT + delta * PPM_PER_LSB);
    assign step_lsb = (straps_r.benchmark_step_level ? STEP_LEVEL_HIGH_PPM
                       : STEP_LEVEL_LOW_PPM) / PPM_PER_LSB;
    assign step_len = straps_r.benchmark_step_interval
                    ? STEP_INTERVAL_SHORT_MIN : STEP_INTERVAL_LONG_MIN;
    assign step_ev = (state_r == ST_RUN) && bench_set_r && !renew
                   && min_tick && (idle_r == step_len - 14'h1); // see R14
    assign bench_up = {1'b0, bench_r} + 11'(step_lsb);

    always_comb begin
        meas_cnt_nxt = meas_cnt_r;
        bench_nxt = bench_r;
        bench_set_nxt = bench_set_r;
        ppm_nxt = ppm_r;
        idle_nxt = idle_r;
        if (state_r == ST_RUN) begin
            meas_cnt_nxt = meas_tick ? 25'h0 : meas_cnt_r + 25'h1;
            if (min_tick) begin
                idle_nxt = idle_r + 14'h1;
            end
        end
        if (renew) begin
            bench_nxt = comp; // see R7
            bench_set_nxt = 1'b1;
            idle_nxt = 14'h0;
            ppm_nxt = PPM_AMBIENT; // see R8
        end else begin
            if (meas_tick) begin
                // delta beyond the scale top would wrap, so clamp it first
                if (delta > (PPM_MAX - PPM_AMBIENT) / PPM_PER_LSB) begin
                    ppm_nxt = PPM_MAX; // see R11
                end else begin
                    ppm_nxt = ppm_raw; // see R6
                end
            end
            // a step landing on a measurement tick must not be lost
            if (step_ev) begin
                bench_nxt = bench_up[10] ? EMF_MAX : bench_up[9:0]; // see R14
                idle_nxt = 14'h0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            meas_cnt_r <= 25'h0;
            bench_r <= 10'h0;
            bench_set_r <= 1'b0;
            ppm_r <= PPM_AMBIENT;
            idle_r <= 14'h0;
        end else begin
            meas_cnt_r <= meas_cnt_nxt;
            bench_r <= bench_nxt;
            bench_set_r <= bench_set_nxt;
            ppm_r <= ppm_nxt;
            idle_r <= idle_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic [11:0] pwm_cnt_r, pwm_cnt_nxt;
    logic pwm_r, pwm_nxt, ctrl_r, ctrl_nxt;
    logic run;

    assign run = (state_r == ST_RUN);

    always_comb begin
        pwm_cnt_nxt = (pwm_cnt_r == PWM_PERIOD - 12'h1) ? 12'h0
                    : pwm_cnt_r + 12'h1;
        pwm_nxt = run && (pwm_cnt_r < ppm_r); // see R4 see R9
        ctrl_nxt = ctrl_r;
        if (!run) begin
            ctrl_nxt = 1'b1; // see R15
        end else if (ppm_r > CTRL_ON_PPM) begin
            ctrl_nxt = 1'b0; // see R10
        end else if (ppm_r < CTRL_OFF_PPM) begin
            ctrl_nxt = 1'b1; // see R10
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pwm_cnt_r <= 12'h0;
            pwm_r <= 1'b0;
            ctrl_r <= 1'b1;
        end else begin
            pwm_cnt_r <= pwm_cnt_nxt;
            pwm_r <= pwm_nxt;
            ctrl_r <= ctrl_nxt;
        end
    end

    assign pwm_out = pwm_r;
    assign ctrl_out = ctrl_r;
    assign ppm_value = run ? ppm_r : 12'h0; // see R4
    assign running = run;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_warm_pwm_low: assert property (!run |=> !pwm_out) // see R4
        else $error("pwm active during warm-up");
    a_warm_ctrl_high: assert property (!$past(run) |-> ctrl_out) // see R15
        else $error("control low during warm-up");
    a_straps_held: assert property ($past(state_r) != ST_LATCH // see R5
        && state_r != ST_LATCH |-> $stable(straps_r))
        else $error("latched straps changed");
    a_warm_length: assert property ($rose(run) // see R3
        && !straps_r.line_test
        |-> $past(min_cnt_r) == warm_len - 14'h1 && $past(min_tick))
        else $error("warm-up length wrong");
    a_start_warmup: assert property (state_r == ST_LATCH // see R1
        |-> ##[1:3] state_r == ST_WARMUP)
        else $error("warm-up did not start");
    a_renew_bench: assert property (renew // see R7
        |=> bench_r == $past(comp) && ppm_r == PPM_AMBIENT)
        else $error("benchmark not renewed");
    a_ppm_span: assert property (run |-> ppm_r >= PPM_AMBIENT // see R11
        && ppm_r <= PPM_MAX)
        else $error("concentration out of span");
    a_step_raise: assert property (step_ev && !bench_up[10] // see R14
        |=> bench_r == $past(bench_r) + 10'(step_lsb))
        else $error("benchmark step wrong");
    a_pwm_duty: assert property (run && ppm_r == PPM_MAX // see R9
        && pwm_cnt_r < PPM_MAX |=> pwm_out)
        else $error("pwm duty wrong");
    a_ctrl_on: assert property (run && $past(run) // see R10
        && ppm_r > CTRL_ON_PPM |=> !ctrl_out)
        else $error("control did not switch");
    a_ppm_calc: assert property (meas_tick && !renew // see R6
        && delta <= (PPM_MAX - PPM_AMBIENT) / PPM_PER_LSB
        |=> ppm_r == PPM_AMBIENT + $past(delta) * PPM_PER_LSB)
        else $error("concentration math wrong");

    c_enter_run: cover property ($rose(run));
    c_renew: cover property (renew && bench_set_r);
    c_step: cover property (step_ev);
    c_ctrl_low: cover property (run && !ctrl_out);
endmodule

// >>> verif/co2ms_sensor_model.sv
// co2ms_sensor_model: converter words of the co2 sensor and thermistor.
// assumes the bench sets target levels; words follow one clock later.
module co2ms_sensor_model (
    input wire logic clk,
    input wire logic [9:0] emf_level,
    input wire logic [11:0] temp_level,
    output logic [9:0] emf_data,
    output logic [11:0] temp_data
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // converter words
    // ------------------------------------------------------------
    // registered so a level change lands like a fresh conversion
    always_ff @(posedge clk) begin
        emf_data <= emf_level;
        temp_data <= temp_level;
    end
endmodule

// >>> verif/testbench.sv
// testbench: warm-up, strap capture and measurement of co2ms_top.
// assumes short minute and tick counts set through the top parameters.
module testbench
    import co2ms_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CPM = 20;
    localparam int CPT = 50;
    logic clk = 1'b0;
    logic reset = 1'b1;
    co2ms_strap_t strap_pins = STRAP_RESET;
    logic [9:0] emf_level = 10'h258;
    logic [11:0] temp_level = 12'h080;
    logic [9:0] emf_data;
    logic [11:0] temp_data;
    logic pwm_out;
    logic ctrl_out;
    logic [11:0] ppm_value;
    logic running;
    int fails = 0;
    int n_compared = 0;
    // ------------------------------------------------------------
    // instances
    // ------------------------------------------------------------
    co2ms_sensor_model sensor (.clk(clk), .emf_level(emf_level),
        .temp_level(temp_level), .emf_data(emf_data),
        .temp_data(temp_data));
    co2ms_top #(.CYC_PER_MIN(CPM), .CYC_PER_MEAS(CPT)) uut (.clk(clk),
        .reset(reset), .strap_pins(strap_pins), .emf_data(emf_data),
        .temp_data(temp_data), .pwm_out(pwm_out), .ctrl_out(ctrl_out),
        .ppm_value(ppm_value), .running(running));
    initial begin
        forever #25 clk = ~clk;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [11:0] exp,
                         input logic [11:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
            fails++;
        end
    endtask
    task automatic do_reset(input co2ms_strap_t s);
        @(posedge clk);
        reset <= 1'b1;
        strap_pins <= s;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
    endtask
    // counts cycles to run while checking the outputs stay quiet
    task automatic warmup(input int lo, input int hi, input logic flip);
        int n;
        n = 0;
        while (running !== 1'b1 && n < hi + 2) begin
            @(posedge clk);
            if (flip && n == 10) strap_pins <= ~strap_pins;
            #1;
            n++;
            if (running !== 1'b1) begin
                check("pwm_out", 12'h000, {11'h000, pwm_out});
                check("ppm_value", 12'h000, ppm_value);
                check("ctrl_out", 12'h001, {11'h000, ctrl_out});
            end
        end
        n_compared++;
        if (running !== 1'b1 || n < lo || n > hi) begin
            $display("mismatch warmup_cycles expected %0d seen %0d", lo, n);
            fails++;
            test_done();
        end
    endtask
    task automatic meas(input logic [9:0] e, input logic [11:0] t,
                        input logic [11:0] ppm, input logic ctrl);
        @(posedge clk);
        emf_level <= e;
        temp_level <= t;
        repeat (2 * CPT + 4) @(posedge clk);
        #1;
        check("ppm_value", ppm, ppm_value);
        check("ctrl_out", {11'h000, ctrl}, ctrl_out);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // strap high gives the short wait; pins flipped later are ignored
    task automatic scen_short_warmup();
        int w;
        w = WARMUP_SHORT_MIN * CPM;
        do_reset(4'h8);
        warmup(w, w + 10, 1'b1);
    endtask
    task automatic scen_long_warmup();
        int w;
        w = WARMUP_LONG_MIN * CPM;
        do_reset(4'h0);
        warmup(w, w + 10, 1'b0);
    endtask
    // benchmark left unrenewed for one short interval rises one step
    task automatic scen_step(input co2ms_strap_t s, input logic [11:0] ppm);
        do_reset(s);
        warmup(0, 8, 1'b0);
        meas(10'h200, 12'h080, PPM_AMBIENT, 1'b1);
        repeat (STEP_INTERVAL_SHORT_MIN * CPM + 2 * CPT) @(posedge clk);
        #1;
        check("ppm_value", ppm, ppm_value);
    endtask
    // line test bypasses warm-up so the whole scale is reached quickly
    task automatic scen_measure();
        int hi_cnt;
        hi_cnt = 0;
        do_reset(4'h1);
        warmup(0, 8, 1'b0);
        meas(10'h258, 12'h080, 12'h190, 1'b1);
        meas(10'h244, 12'h080, 12'h1f4, 1'b1);
        meas(10'h190, 12'h080, 12'h578, 1'b0);
        repeat (3000) begin
            @(posedge clk);
            #1;
            if (pwm_out === 1'b1) hi_cnt++;
        end
        n_compared++;
        if (hi_cnt < 1399 || hi_cnt > 1401) begin
            $display("mismatch pwm_high expected 1400 seen %0d", hi_cnt);
            fails++;
        end
        meas(10'h000, 12'h080, PPM_MAX, 1'b0);
        meas(10'h262, 12'h080, 12'h190, 1'b1);
        meas(10'h254, 12'h0a0, 12'h1c2, 1'b1);
    endtask
    initial begin
        scen_short_warmup();
        scen_long_warmup();
        scen_measure();
        scen_step(4'h3, PPM_AMBIENT + STEP_LEVEL_LOW_PPM);
        scen_step(4'h7, PPM_AMBIENT + STEP_LEVEL_HIGH_PPM);
        test_done();
    end
endmodule
